// *** ccsw_top.sv ***
// Clock source switch controller with AXI4-Lite register access
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ccsw_top
    import ccsw_pkg::*;
#(
    parameter logic [15:0] START_CYCLES = CCSW_START_CYCLES,
    parameter logic [3:0] XTAL_SRC_MASK = 4'h4,
    parameter logic [3:0] PLL_SRC_MASK = 4'h8
)
(
    input wire logic CLK,
    input wire logic RESET,
    // AXI4-Lite slave
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Clock system side
    input wire logic NEW_CLK_TICK,
    input wire logic PLL_LOCK,
    input wire logic SLEEP_REQ,
    output logic SLEEP_ACK,
    output logic [1:0] CUR_SOURCE,
    output logic PLL_EN,
    output logic XTAL_EN,
    output logic IRQ
);
    // ************************************************************
    // State of the block outside the timer and unlock filters
    // ************************************************************
    typedef struct packed {
        ccsw_state_type st; // Sequencer state
        logic req; // Switch request bit
        logic lock; // Loop lock status
        logic [1:0] nxt; // Next source field
        logic [1:0] cur; // Current source field
        logic pll_en; // Loop enable
        logic xtal_en; // Crystal enable
        logic sleep_ack; // Power-save proceed pulse
        logic [2:0] sts; // Sticky events
        logic [2:0] msk; // Event mask
        logic irq; // Interrupt line
        logic awready; // Write address taken
        logic wready; // Write data taken
        logic bvalid; // Write answer
        logic [1:0] bresp; // Write answer code
        logic arready; // Read address taken
        logic rvalid; // Read answer
        logic [31:0] rdata; // Read data
        logic [1:0] rresp; // Read answer code
    } ccsw_regs_type;

    ccsw_regs_type r_reg;
    ccsw_regs_type r_next;

    ccsw_tmr_if tmr_bus ();

    logic wr_fire; // Write performed this cycle
    logic rd_fire; // Read performed this cycle
    logic ctrl_wr; // Write hits control register
    logic [1:0] lane_wr; // Per-byte control write
    logic [1:0] lane_open; // Per-byte unlocked write
    logic [15:0] lane_data; // Low two data bytes
    logic lo_go; // Unlocked low write, bit 0 set
    logic lo_stop; // Unlocked low write, bit 0 clear
    logic busy; // Switch under way
    logic abort_sw; // Software abort
    logic abort_slp; // Sleep abort
    // Key pairs per byte lane
    localparam logic [7:0] KEY1_TAB [0:1] = '{CCSW_KEY_LO1, CCSW_KEY_HI1};
    localparam logic [7:0] KEY2_TAB [0:1] = '{CCSW_KEY_LO2, CCSW_KEY_HI2};

    // ************************************************************
    // Bus decode
    // ************************************************************
    assign wr_fire = r_reg.awready && r_reg.wready;
    assign rd_fire = r_reg.arready;
    assign ctrl_wr = wr_fire && (S_AXI_AWADDR == CCSW_CTRL_OFS);
    assign lane_data = S_AXI_WDATA[15:0];

    // One unlock filter per control byte
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_lane
            assign lane_wr[g] = ctrl_wr && S_AXI_WSTRB[g];
            ccsw_unlock #(
                .KEY1(KEY1_TAB[g]),
                .KEY2(KEY2_TAB[g])
            ) u_unlock (
                .CLK(CLK),
                .RESET(RESET),
                .WR(lane_wr[g]),
                .OTHER_WR(wr_fire && !lane_wr[g]),
                .DATA(lane_data[8*g +: 8]),
                .OPEN(lane_open[g])
            );
        end
    endgenerate

    // Low byte data write decode
    assign lo_go = lane_open[0] && lane_data[CCSW_REQ_BIT];
    assign lo_stop = lane_open[0] && !lane_data[CCSW_REQ_BIT];
    assign busy = (r_reg.st != CCSW_IDLE);
    assign abort_sw = lo_stop && r_reg.req;
    assign abort_slp = SLEEP_REQ && r_reg.req;

    // ************************************************************
    // Timer control
    // ************************************************************
    assign tmr_bus.run = (r_reg.st == CCSW_START_WAIT) || (r_reg.st == CCSW_SYNC_WAIT);
    assign tmr_bus.clr = (r_next.st != r_reg.st);
    assign tmr_bus.tick = NEW_CLK_TICK;
    assign tmr_bus.target = (r_reg.st == CCSW_START_WAIT) ? START_CYCLES : CCSW_SYNC_CYCLES;

    ccsw_tmr u_tmr (
        .CLK(CLK),
        .RESET(RESET),
        .t(tmr_bus.tmr)
    );

    // Register readback
    function automatic logic [31:0] rd_mux(input logic [3:0] a, input ccsw_regs_type s);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            CCSW_CTRL_OFS:
            begin
                v[CCSW_REQ_BIT] = s.req;
                v[CCSW_LOCK_BIT] = s.lock;
                v[CCSW_NXT_LSB +: 2] = s.nxt;
                v[CCSW_CUR_LSB +: 2] = s.cur;
            end
            CCSW_STAT_OFS: v[CCSW_EV_NUM-1:0] = s.sts;
            CCSW_MASK_OFS: v[CCSW_EV_NUM-1:0] = s.msk;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : rd_mux

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        logic [2:0] ev;
        ev = 3'h0;
        r_next = r_reg;
        r_next.lock = PLL_LOCK;
        r_next.sleep_ack = SLEEP_REQ;

        // AXI write channel: take address and data together
        r_next.awready = 1'b0;
        r_next.wready = 1'b0;
        if (S_AXI_AWVALID && S_AXI_WVALID && !wr_fire && !r_reg.bvalid)
        begin
            r_next.awready = 1'b1;
            r_next.wready = 1'b1;
        end
        if (wr_fire)
        begin
            // Answer follows both
            r_next.bvalid = 1'b1;
            r_next.bresp = (S_AXI_AWADDR > CCSW_MASK_OFS || S_AXI_AWADDR[1:0] != 2'h0)
                ? CCSW_RESP_DEC : CCSW_RESP_OK;
        end
        else if (r_reg.bvalid && S_AXI_BREADY)
        begin
            r_next.bvalid = 1'b0;
        end

        // AXI read channel
        r_next.arready = S_AXI_ARVALID && !r_reg.arready && !r_reg.rvalid;
        if (rd_fire)
        begin
            r_next.rvalid = 1'b1;
            r_next.rdata = rd_mux(S_AXI_ARADDR, r_reg);
            r_next.rresp = (S_AXI_ARADDR > CCSW_MASK_OFS || S_AXI_ARADDR[1:0] != 2'h0)
                ? CCSW_RESP_DEC : CCSW_RESP_OK;
        end
        else if (r_reg.rvalid && S_AXI_RREADY)
        begin
            r_next.rvalid = 1'b0;
        end

        // Mask register
        if (wr_fire && S_AXI_AWADDR == CCSW_MASK_OFS && S_AXI_WSTRB[0])
        begin
            r_next.msk = S_AXI_WDATA[CCSW_EV_NUM-1:0];
        end

        // Next source, only while no switch is under way
        if (lane_open[1] && !r_reg.req)
        begin
            r_next.nxt = lane_data[CCSW_NXT_LSB +: 2];
        end

        // Switch sequencer
        if (abort_sw || abort_slp)
        begin
            // Drop back to the old source
            r_next.st = CCSW_IDLE;
            r_next.req = 1'b0;
            r_next.pll_en = PLL_SRC_MASK[r_reg.cur];
            r_next.xtal_en = XTAL_SRC_MASK[r_reg.cur];
            ev[CCSW_EV_ABORT] = 1'b1;
        end
        else
        begin
            case (r_reg.st)
                CCSW_IDLE:
                begin
                    if (lo_go && !r_reg.req)
                    begin
                        if (r_reg.nxt == r_reg.cur)
                        begin
                            // Nothing to change
                            ev[CCSW_EV_SAME] = 1'b1;
                        end
                        else
                        begin
                            // Start new source and wait for it
                            r_next.req = 1'b1;
                            r_next.lock = 1'b0;
                            r_next.xtal_en = r_reg.xtal_en | XTAL_SRC_MASK[r_reg.nxt];
                            r_next.pll_en = r_reg.pll_en | PLL_SRC_MASK[r_reg.nxt];
                            if (XTAL_SRC_MASK[r_reg.nxt])
                            begin
                                r_next.st = CCSW_START_WAIT;
                            end
                            else if (PLL_SRC_MASK[r_reg.nxt])
                            begin
                                r_next.st = CCSW_LOCK_WAIT;
                            end
                            else
                            begin
                                r_next.st = CCSW_SYNC_WAIT;
                            end
                        end
                    end
                end
                CCSW_START_WAIT:
                begin
                    // Crystal start-up time
                    if (tmr_bus.done)
                    begin
                        r_next.st = PLL_SRC_MASK[r_reg.nxt] ? CCSW_LOCK_WAIT
                            : CCSW_SYNC_WAIT;
                    end
                end
                CCSW_LOCK_WAIT:
                begin
                    // Loop lock
                    if (PLL_LOCK)
                    begin
                        r_next.st = CCSW_SYNC_WAIT;
                    end
                end
                CCSW_SYNC_WAIT:
                begin
                    // Ten new-clock cycles, then change over
                    if (tmr_bus.done)
                    begin
                        r_next.st = CCSW_IDLE;
                        r_next.req = 1'b0;
                        r_next.cur = r_reg.nxt;
                        r_next.pll_en = PLL_SRC_MASK[r_reg.nxt];
                        r_next.xtal_en = XTAL_SRC_MASK[r_reg.nxt];
                        ev[CCSW_EV_DONE] = 1'b1;
                    end
                end
                default:
                begin
                    r_next.st = CCSW_IDLE;
                end
            endcase
        end

        // Sticky events: write one to clear, a new event wins
        if (wr_fire && S_AXI_AWADDR == CCSW_STAT_OFS && S_AXI_WSTRB[0])
        begin
            r_next.sts = r_reg.sts & ~S_AXI_WDATA[CCSW_EV_NUM-1:0];
        end
        r_next.sts = r_next.sts | ev;
        r_next.irq = |(r_next.sts & r_next.msk);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            r_reg <= '0;
            r_reg.cur <= CCSW_CUR_RST;
            r_reg.msk <= CCSW_MASK_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from flops
    assign S_AXI_AWREADY = r_reg.awready;
    assign S_AXI_WREADY = r_reg.wready;
    assign S_AXI_BVALID = r_reg.bvalid;
    assign S_AXI_BRESP = r_reg.bresp;
    assign S_AXI_ARREADY = r_reg.arready;
    assign S_AXI_RVALID = r_reg.rvalid;
    assign S_AXI_RDATA = r_reg.rdata;
    assign S_AXI_RRESP = r_reg.rresp;
    assign SLEEP_ACK = r_reg.sleep_ack;
    assign CUR_SOURCE = r_reg.cur;
    assign PLL_EN = r_reg.pll_en;
    assign XTAL_EN = r_reg.xtal_en;
    assign IRQ = r_reg.irq;
    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    a_abort_idle: assert property (abort_sw |=> r_reg.st == CCSW_IDLE && !r_reg.req)
        else $error("Software abort did not return to idle");
    a_abort_timer: assert property (abort_sw && tmr_bus.run |=> !tmr_bus.run)
        else $error("Start-up timer kept running after abort");
    a_abort_pll: assert property (abort_sw && !PLL_SRC_MASK[r_reg.cur] |=> !PLL_EN)
        else $error("Loop left on after abort");
    a_abort_lockw: assert property (r_reg.st == CCSW_LOCK_WAIT && abort_sw
        |=> r_reg.st == CCSW_IDLE)
        else $error("Abort ignored while waiting on lock");
    a_sleep_cancel: assert property (SLEEP_REQ && busy
        |=> !r_reg.req && $stable(CUR_SOURCE))
        else $error("Sleep did not cancel the switch");
    a_sleep_ack: assert property (SLEEP_REQ |=> SLEEP_ACK)
        else $error("Power-save not carried out after sleep entry");
    a_high_locked: assert property (lane_wr[1] && !lane_open[1] |=> $stable(r_reg.nxt))
        else $error("High byte changed without unlock");
    a_same_src: assert property (lo_go && !r_reg.req && r_reg.nxt == r_reg.cur
        |=> !r_reg.req && r_reg.st == CCSW_IDLE)
        else $error("Redundant switch left request set");
    a_done_copy: assert property (r_reg.st == CCSW_SYNC_WAIT && tmr_bus.done && !abort_sw
        && !SLEEP_REQ |=> CUR_SOURCE == $past(r_reg.nxt) && !r_reg.req)
        else $error("Completed switch did not copy source");
    a_sync_hold: assert property (r_reg.st == CCSW_SYNC_WAIT && !tmr_bus.done && !abort_sw
        && !SLEEP_REQ |=> r_reg.st == CCSW_SYNC_WAIT)
        else $error("Changed over before sync cycles");
    a_abort_keep: assert property (abort_sw |=> $stable(CUR_SOURCE))
        else $error("Current source changed on abort");
    a_go_start: assert property (lo_go && !r_reg.req && r_reg.nxt != r_reg.cur
        |=> r_reg.req && busy)
        else $error("Request write did not start a switch");
endmodule : ccsw_top
`default_nettype wire

// *** ccsw_pkg.sv ***
// Constants, register map and types shared by the clock switch control block
package ccsw_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [3:0] CCSW_CTRL_OFS = 4'h0;
    localparam logic [3:0] CCSW_STAT_OFS = 4'h4;
    localparam logic [3:0] CCSW_MASK_OFS = 4'h8;

    // Control register field positions
    localparam int CCSW_REQ_BIT = 0;
    localparam int CCSW_LOCK_BIT = 5;
    localparam int CCSW_NXT_LSB = 8;
    localparam int CCSW_CUR_LSB = 12;

    // Status and mask bit positions
    localparam int CCSW_EV_DONE = 0;
    localparam int CCSW_EV_ABORT = 1;
    localparam int CCSW_EV_SAME = 2;
    localparam int CCSW_EV_NUM = 3;

    // Reset values
    localparam logic [1:0] CCSW_CUR_RST = 2'h0;
    localparam logic [2:0] CCSW_MASK_RST = 3'h0;

    // Unlock keys, low byte and high byte
    localparam logic [7:0] CCSW_KEY_LO1 = 8'h46;
    localparam logic [7:0] CCSW_KEY_LO2 = 8'h57;
    localparam logic [7:0] CCSW_KEY_HI1 = 8'h78;
    localparam logic [7:0] CCSW_KEY_HI2 = 8'h9A;

    // ************************************************************
    // Timing counts, in cycles of the new clock
    // ************************************************************
    localparam int CCSW_TMR_W = 16;
    localparam logic [15:0] CCSW_START_CYCLES = 16'h0400;
    localparam logic [15:0] CCSW_SYNC_CYCLES = 16'h000A;

    // AXI responses
    localparam logic [1:0] CCSW_RESP_OK = 2'h0;
    localparam logic [1:0] CCSW_RESP_DEC = 2'h3;

    // Switch sequencer states
    typedef enum logic [1:0] {
        CCSW_IDLE = 2'b00,
        CCSW_START_WAIT = 2'b01,
        CCSW_LOCK_WAIT = 2'b10,
        CCSW_SYNC_WAIT = 2'b11
    } ccsw_state_type;

endpackage : ccsw_pkg

// *** ccsw_tmr_if.sv ***
// Interface between the switch sequencer and its cycle timer
`timescale 1ns/10ps
`default_nettype none
interface ccsw_tmr_if;
    logic run; // Timer counts while high
    logic clr; // Restart count from zero
    logic tick; // One new-clock cycle seen
    logic [15:0] target; // Count to reach
    logic done; // Target reached
    modport ctl (output run, output clr, output tick, output target, input done);
    modport tmr (input run, input clr, input tick, input target, output done);
endinterface : ccsw_tmr_if
`default_nettype wire

// *** ccsw_tmr.sv ***
// Start-up and synchronisation cycle timer
`timescale 1ns/10ps
`default_nettype none
module ccsw_tmr
    import ccsw_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    ccsw_tmr_if.tmr t
);
    // State of the timer
    typedef struct packed {
        logic [15:0] cnt;
    } ccsw_tmr_type;

    ccsw_tmr_type r_reg;
    ccsw_tmr_type r_next;

    // ************************************************************
    // Count new-clock ticks while running
    // ************************************************************
    always_comb
    begin
        r_next = r_reg;
        if (!t.run || t.clr)
        begin
            // Held at zero when stopped
            r_next.cnt = '0;
        end
        else if (t.tick && !t.done)
        begin
            r_next.cnt = r_reg.cnt + 16'h0001;
        end
    end

    // Target reached
    assign t.done = t.run && (r_reg.cnt >= t.target);

    // State register
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end
endmodule : ccsw_tmr
`default_nettype wire

// *** ccsw_unlock.sv ***
// Two-key unlock filter for one control byte
`timescale 1ns/10ps
`default_nettype none
module ccsw_unlock
    import ccsw_pkg::*;
#(
    parameter logic [7:0] KEY1 = 8'h00,
    parameter logic [7:0] KEY2 = 8'h00
)
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic WR,
    input wire logic OTHER_WR,
    input wire logic [7:0] DATA,
    output logic OPEN
);
    // Progress through the key pair
    typedef struct packed {
        logic got1;
        logic open;
    } ccsw_ulk_type;

    ccsw_ulk_type r_reg;
    ccsw_ulk_type r_next;

    // ************************************************************
    // Key tracking; any foreign write breaks the sequence
    // ************************************************************
    always_comb
    begin
        r_next = r_reg;
        if (WR)
        begin
            // Data write consumes the unlock, keys re-arm
            r_next.open = !r_reg.open && r_reg.got1 && (DATA == KEY2);
            r_next.got1 = !r_next.open && (DATA == KEY1);
        end
        else if (OTHER_WR)
        begin
            r_next = '0;
        end
    end

    // This write is the one allowed through
    assign OPEN = WR && r_reg.open;

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end
endmodule : ccsw_unlock
`default_nettype wire

// *** clock_switch_control_tb.sv ***
// Self-checking testbench for the clock source switch controller
`timescale 1ns/10ps
`default_nettype none
module clock_switch_control_tb import ccsw_pkg::*;;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rv;
    logic awvalid, wvalid, bready, arvalid, rready, tick, lock, sleep;
    logic awready, wready, bvalid, arready, rvalid, sack, pllen, xten, irq;
    logic [1:0] bresp, rresp, cur, rr, br;
    logic [15:0] lf = 16'h0005; // Random source, fixed start
    int mismatches = 0;
    int checks = 0;

    // Short start-up count keeps the run brief
    ccsw_top #(.START_CYCLES(16'h0004)) u_ccsw_top (.CLK(clk), .RESET(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .NEW_CLK_TICK(tick),
        .PLL_LOCK(lock), .SLEEP_REQ(sleep), .SLEEP_ACK(sack), .CUR_SOURCE(cur),
        .PLL_EN(pllen), .XTAL_EN(xten), .IRQ(irq));

    // Clock and random new-clock ticks
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        lf <= nxt_lf(lf);
        tick <= lf[0];
    end

    // ************************************************************
    // Expectations and bus tasks
    // ************************************************************
    function logic [15:0] nxt_lf(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt_lf

    // Expected control word from request, next and current source
    function logic [31:0] ctrl_w(input logic q, input logic [1:0] n, input logic [1:0] c);
        return {18'h0_0000, c, 2'h0, n, 2'h0, lock, 4'h0, q};
    endfunction : ctrl_w

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (!bvalid) @(posedge clk);
        br = bresp;
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask : rd

    // Unlock high byte, write next source
    task hi(input logic [1:0] n);
        wr(CCSW_CTRL_OFS, {16'h0000, CCSW_KEY_HI1, 8'h00}, 4'h2);
        wr(CCSW_CTRL_OFS, {16'h0000, CCSW_KEY_HI2, 8'h00}, 4'h2);
        wr(CCSW_CTRL_OFS, {22'h00_0000, n, 8'h00}, 4'h2);
    endtask : hi

    // Unlock low byte, write request bit
    task lo(input logic b);
        wr(CCSW_CTRL_OFS, {24'h00_0000, CCSW_KEY_LO1}, 4'h1);
        wr(CCSW_CTRL_OFS, {24'h00_0000, CCSW_KEY_LO2}, 4'h1);
        wr(CCSW_CTRL_OFS, {31'h0000_0000, b}, 4'h1);
    endtask : lo

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial
    begin
        {awaddr, araddr, wstrb, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready, lock, sleep} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(CCSW_CTRL_OFS);
        chk(rv, ctrl_w(1'b0, 2'h0, CCSW_CUR_RST));
        wr(CCSW_MASK_OFS, 32'h0000_0001, 4'hF);
        chk(br, CCSW_RESP_OK);
        // Key pair broken by another write
        wr(CCSW_CTRL_OFS, {16'h0000, CCSW_KEY_HI1, 8'h00}, 4'h2);
        wr(CCSW_CTRL_OFS, {16'h0000, CCSW_KEY_HI2, 8'h00}, 4'h2);
        wr(CCSW_MASK_OFS, 32'h0000_0001, 4'hF);
        wr(CCSW_CTRL_OFS, 32'h0000_0300, 4'h2);
        rd(CCSW_CTRL_OFS);
        chk(rv, ctrl_w(1'b0, 2'h0, 2'h0));
        $display("test 1 done");
        // Loop switch stuck on lock, then aborted
        hi(2'h3);
        lo(1'b1);
        rd(CCSW_CTRL_OFS);
        chk(rv, ctrl_w(1'b1, 2'h3, 2'h0));
        chk({xten, pllen}, 2'b01);
        lo(1'b0);
        rd(CCSW_CTRL_OFS);
        chk(rv, ctrl_w(1'b0, 2'h3, 2'h0));
        chk({xten, pllen, cur, irq}, 5'h00);
        rd(CCSW_STAT_OFS);
        chk(rv, 32'h0000_0002);
        wr(CCSW_STAT_OFS, 32'h0000_0007, 4'hF);
        $display("test 2 done");
        // Crystal switch aborted early, then completed
        hi(2'h2);
        lo(1'b1);
        chk({xten, pllen}, 2'b10);
        lo(1'b0);
        chk({xten, cur}, 3'h0);
        lo(1'b1);
        do rd(CCSW_CTRL_OFS); while (rv[0]);
        chk(rv, ctrl_w(1'b0, 2'h2, 2'h2));
        chk({xten, pllen, cur, irq}, 5'h15);
        wr(CCSW_STAT_OFS, 32'h0000_0007, 4'hF);
        lo(1'b1);
        rd(CCSW_STAT_OFS);
        chk(rv, 32'h0000_0004);
        chk(irq, 1'b0);
        $display("test 3 done");
        // Sleep during pending loop switch
        hi(2'h3);
        lo(1'b1);
        sleep <= 1'b1;
        @(posedge clk);
        sleep <= 1'b0;
        #1;
        chk(sack, 1'b1);
        rd(CCSW_CTRL_OFS);
        chk(rv, ctrl_w(1'b0, 2'h3, 2'h2));
        chk({xten, pllen}, 2'b10);
        lock <= 1'b1;
        lo(1'b1);
        do rd(CCSW_CTRL_OFS); while (rv[0]);
        chk(rv, ctrl_w(1'b0, 2'h3, 2'h3));
        chk({xten, pllen}, 2'b01);
        rd(4'hC);
        chk(rr, CCSW_RESP_DEC);
        wr(4'hC, 32'h0000_0001, 4'hF);
        chk(br, CCSW_RESP_DEC);
        $display("test 4 done");
        report_and_stop;
    end

    // Watchdog against a hung handshake
    initial
    begin
        #200000;
        mismatches++;
        report_and_stop;
    end
endmodule : clock_switch_control_tb
`default_nettype wire
